// >>> addr_mode_pkg.sv
`default_nettype none
package addr_mode_pkg;

	// Addressing modes as seen after prebyte resolution
	typedef enum logic [3:0] {
		M_INH   = 4'h0,
		M_IMM   = 4'h1,
		M_DIR_S = 4'h2,
		M_DIR_L = 4'h3,
		M_IDX0  = 4'h4,
		M_IDX_S = 4'h5,
		M_IDX_L = 4'h6,
		M_IND_S = 4'h7,
		M_IND_L = 4'h8,
		M_IIX_S = 4'h9,
		M_IIX_L = 4'hA,
		M_REL_D = 4'hB,
		M_REL_I = 4'hC
	} mode_t;

	// Operation families by the mode set they accept
	typedef enum logic [1:0] {
		OP_INH   = 2'h0,
		OP_FULL  = 2'h1,
		OP_SHORT = 2'h2,
		OP_REL   = 2'h3
	} op_class_t;

	// Sequencer states, Gray along idle-arg1-arg2-fin
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ARG1 = 3'h1,
		S_ARG2 = 3'h3,
		S_PTR1 = 3'h2,
		S_PTR2 = 3'h6,
		S_FIN  = 3'h7
	} state_t;

	////////////////////////////////////////////////////////////////////
	// Prebyte codes
	localparam logic [7:0] PRE_SECOND_INDEX    = 8'h90;
	localparam logic [7:0] PRE_SECOND_INDIRECT = 8'h91;
	localparam logic [7:0] PRE_INDIRECT        = 8'h92;

	// Reset values
	localparam logic [15:0] ADDR_RST  = 16'h0000;
	localparam logic [7:0]  ZERO_PAGE = 8'h00;
	localparam logic [1:0]  RST_SYNC_RST = 2'h0;

	////////////////////////////////////////////////////////////////////
	// Bytes that follow the opcode
	function automatic logic [1:0] mode_len(input mode_t m);
		unique case (m)
			M_INH, M_IDX0:   mode_len = 2'h0;
			M_DIR_L, M_IDX_L: mode_len = 2'h2;
			default:         mode_len = 2'h1;
		endcase
	endfunction : mode_len

	// Modes that read a pointer or offset from memory
	function automatic logic is_indirect(input mode_t m);
		is_indirect = m inside {M_IND_S, M_IND_L, M_IIX_S, M_IIX_L,
			M_REL_I};
	endfunction : is_indirect

	// Modes whose pointer value is a word
	function automatic logic long_ptr(input mode_t m);
		long_ptr = m inside {M_IND_L, M_IIX_L};
	endfunction : long_ptr

	// Direct and indexed forms turned into their indirect twins
	function automatic mode_t to_indirect(input mode_t m);
		unique case (m)
			M_DIR_S: to_indirect = M_IND_S;
			M_DIR_L: to_indirect = M_IND_L;
			M_IDX_S: to_indirect = M_IIX_S;
			M_IDX_L: to_indirect = M_IIX_L;
			M_REL_D: to_indirect = M_REL_I;
			default: to_indirect = m;
		endcase
	endfunction : to_indirect

	// Which operation family accepts which mode
	function automatic logic mode_ok(input op_class_t c, input mode_t m);
		unique case (c)
			OP_INH:   mode_ok = (m == M_INH);
			OP_FULL:  mode_ok = !(m inside {M_INH, M_REL_D, M_REL_I});
			OP_SHORT: mode_ok = m inside {M_INH, M_DIR_S, M_IDX0,
				M_IDX_S, M_IND_S, M_IIX_S};
			OP_REL:   mode_ok = m inside {M_REL_D, M_REL_I};
		endcase
	endfunction : mode_ok

endpackage : addr_mode_pkg
`default_nettype wire

// >>> ea_if.sv
`default_nettype none
interface ea_if;
	import addr_mode_pkg::*;

	mode_t       mode;
	logic [7:0]  index;
	logic [15:0] word;
	logic [15:0] next_pc;
	logic [15:0] ea;

	modport calc (input mode, input index, input word, input next_pc,
		output ea);
	modport user (output mode, output index, output word,
		output next_pc, input ea);
endinterface : ea_if
`default_nettype wire

// >>> ea_calc.sv
`default_nettype none
module ea_calc
	import addr_mode_pkg::*;
(
	ea_if.calc bus
);

	// Effective address from mode, index, fetched word and next pc
	always_comb begin
		logic [8:0] short_sum;
		short_sum = {1'b0, bus.index} + {1'b0, bus.word[7:0]};
		unique case (bus.mode)
			M_DIR_S, M_IND_S: bus.ea = {ZERO_PAGE, bus.word[7:0]};
			M_DIR_L, M_IND_L: bus.ea = bus.word;
			M_IDX0:           bus.ea = {ZERO_PAGE, bus.index};
			M_IDX_S, M_IIX_S: bus.ea = {7'h00, short_sum};
			M_IDX_L, M_IIX_L: bus.ea = bus.word + {ZERO_PAGE, bus.index};
			M_REL_D, M_REL_I: bus.ea = bus.next_pc +
				{{8{bus.word[7]}}, bus.word[7:0]};
			M_IMM:            bus.ea = bus.next_pc - 16'h0001;
			default:          bus.ea = ADDR_RST;
		endcase
	end

endmodule : ea_calc
`default_nettype wire

// >>> addr_mode_decoder.sv
// Summary of operation
// - Inherent instructions are one byte; nothing fetched after opcode.
// - Inherent family covers control, flag, stack and register-only ops.
// - Immediate is opcode plus one literal byte: load/compare/logic/add.
// - Short direct: one address byte, operand within 00 - FF.
// - Long direct: two address bytes, whole 64 Kbyte space.
// - Indexed address is unsigned index register plus instruction offset.
// - Indexed without offset uses the index alone; no byte follows.
// - Short indexed: one offset byte, sum reaches 1FE.
// - Long indexed: two offset bytes, whole 64 Kbyte space.
// - Indirect: pointer address byte follows; operand address read there.
// - Short indirect: byte pointer, operand in 00 - FF, one byte.
// - Long indirect forms read a word pointer via one byte address.
// - Indirect indexed address is index plus fetched pointer value.
// - Short indirect indexed: byte pointer plus index, up to 1FE.
// - Load, compare, logic, add/sub accept short and long memory modes.
// - Read-modify-write, bit, call and jump ops accept short forms only.
// - Relative adds an 8-bit signed offset to the program counter.
// - Direct relative takes the offset byte right after the opcode.
// - Indirect relative reads the offset from memory at given address.
// - Offset adds to pc of next instruction: reach -128 to +127.
// - Prebyte 90 selects the second index register.
// - Prebyte 92 turns direct/indexed/relative into indirect forms.
// - Prebyte 91 makes indirect indexed use the second index register.
`default_nettype none
module addr_mode_decoder
	import addr_mode_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        start_i,
	input  wire mode_t       mode_i,
	input  wire op_class_t   op_class_i,
	input  wire logic [7:0]  prebyte_i,
	input  wire logic [15:0] opc_addr_i,
	input  wire logic [7:0]  x_i,
	input  wire logic [7:0]  y_i,
	input  wire logic        mem_ack_i,
	input  wire logic [7:0]  mem_rdata_i,
	output logic             mem_req_o,
	output logic [15:0]      mem_addr_o,
	output logic             busy_o,
	output logic             done_o,
	output logic             err_o,
	output logic [15:0]      ea_o,
	output logic [1:0]       len_o,
	output mode_t            mode_o,
	output logic [7:0]       operand_o,
	output logic [15:0]      next_pc_o
);

	logic [1:0]  rst_sync_q;
	logic        rst_n;
	state_t      st_q;
	mode_t       mode_q;
	mode_t       eff_mode;
	logic        eff_y;
	logic        start_ok;
	logic        take;
	logic [7:0]  idx_q;
	logic [1:0]  len_q;
	logic        bad_q;
	logic [15:0] npc_q;
	logic [15:0] word_q;

	ea_if eif ();

	////////////////////////////////////////////////////////////////////
	// Reset release through two flops; asserts at once
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_q <= RST_SYNC_RST;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////
	// Prebyte resolution of mode and index register
	always_comb begin
		eff_mode = mode_i;
		eff_y    = 1'b0;
		unique case (prebyte_i)
			PRE_SECOND_INDEX: begin
				eff_y = mode_i inside {M_INH, M_IMM, M_DIR_S, M_DIR_L,
					M_IDX0, M_IDX_S, M_IDX_L};
			end
			PRE_INDIRECT: begin
				eff_mode = to_indirect(mode_i);
			end
			PRE_SECOND_INDIRECT: begin
				if (mode_i inside {M_IDX_S, M_IDX_L, M_IIX_S, M_IIX_L}) begin
					eff_mode = to_indirect(mode_i);
					eff_y    = 1'b1;
				end
			end
			default: begin
				eff_mode = mode_i;
			end
		endcase
	end

	assign start_ok = mode_ok(op_class_i, eff_mode);
	// Requests while busy are ignored, not queued
	assign take = (st_q == S_IDLE) && start_i;

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (take) begin
						st_q <= (!start_ok || mode_len(eff_mode) == 2'h0) ?
							S_FIN : S_ARG1;
					end
				end
				S_ARG1: begin
					if (mem_ack_i) begin
						if (len_q == 2'h2) begin
							st_q <= S_ARG2;
						end else if (is_indirect(mode_q)) begin
							st_q <= S_PTR1;
						end else begin
							st_q <= S_FIN;
						end
					end
				end
				S_ARG2: begin
					if (mem_ack_i) begin
						st_q <= S_FIN;
					end
				end
				S_PTR1: begin
					if (mem_ack_i) begin
						st_q <= long_ptr(mode_q) ? S_PTR2 : S_FIN;
					end
				end
				S_PTR2: begin
					if (mem_ack_i) begin
						st_q <= S_FIN;
					end
				end
				S_FIN: begin
					st_q <= S_IDLE;
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Instruction context captured when a request is taken
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= M_INH;
			idx_q  <= ZERO_PAGE;
			len_q  <= 2'h0;
			bad_q  <= 1'b0;
			npc_q  <= ADDR_RST;
		end else if (take) begin
			mode_q <= eff_mode;
			idx_q  <= eff_y ? y_i : x_i;
			len_q  <= mode_len(eff_mode);
			bad_q  <= !start_ok;
			npc_q  <= opc_addr_i + {14'h0000, mode_len(eff_mode)} +
				16'h0001;
		end
	end

	// Operand word; bytes arrive high first
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= ADDR_RST;
		end else if (take) begin
			word_q <= ADDR_RST;
		end else if (mem_ack_i) begin
			unique case (st_q)
				S_ARG1: word_q <= {ZERO_PAGE, mem_rdata_i};
				S_ARG2: word_q <= {word_q[7:0], mem_rdata_i};
				S_PTR1: word_q <= long_ptr(mode_q) ?
					{mem_rdata_i, ZERO_PAGE} : {ZERO_PAGE, mem_rdata_i};
				S_PTR2: word_q <= {word_q[15:8], mem_rdata_i};
				default: word_q <= word_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory port; request held until acknowledged
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_req_o  <= 1'b0;
			mem_addr_o <= ADDR_RST;
		end else if (take) begin
			mem_req_o  <= start_ok && mode_len(eff_mode) != 2'h0;
			mem_addr_o <= opc_addr_i + 16'h0001;
		end else if (mem_ack_i && mem_req_o) begin
			unique case (st_q)
				S_ARG1: begin
					if (len_q == 2'h2) begin
						mem_addr_o <= mem_addr_o + 16'h0001;
					end else begin
						mem_addr_o <= {ZERO_PAGE, mem_rdata_i};
					end
					mem_req_o <= (len_q == 2'h2) || is_indirect(mode_q);
				end
				S_PTR1: begin
					mem_req_o  <= long_ptr(mode_q);
					mem_addr_o <= mem_addr_o + 16'h0001;
				end
				default: begin
					mem_req_o <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Address unit
	assign eif.mode    = mode_q;
	assign eif.index   = idx_q;
	assign eif.word    = word_q;
	assign eif.next_pc = npc_q;

	ea_calc u_ea_calc (
		.bus (eif.calc)
	);

	// Result registers; done is a one-cycle pulse after fin
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			err_o     <= 1'b0;
			ea_o      <= ADDR_RST;
			len_o     <= 2'h0;
			mode_o    <= M_INH;
			operand_o <= ZERO_PAGE;
			next_pc_o <= ADDR_RST;
		end else begin
			busy_o <= take || (busy_o && st_q != S_FIN);
			done_o <= (st_q == S_FIN);
			if (st_q == S_FIN) begin
				err_o     <= bad_q;
				ea_o      <= bad_q ? ADDR_RST : eif.ea;
				len_o     <= len_q;
				mode_o    <= mode_q;
				operand_o <= word_q[7:0];
				next_pc_o <= npc_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		st_q == S_IDLE && start_i;
	endsequence

	sequence s_done_ok;
		done_o && !err_o;
	endsequence

	a_inh_one_byte: assert property (
		s_take ##0 (eff_mode == M_INH && start_ok) |->
		!mem_req_o [*3] ##0 (done_o && len_o == 2'h0))
		else $error("inherent took operand bytes");

	a_inh_family_only: assert property (
		s_take ##0 (op_class_i == OP_INH && eff_mode != M_INH) |->
		##2 done_o && err_o)
		else $error("inherent family accepted memory mode");

	a_imm_literal: assert property (
		s_done_ok ##0 mode_o == M_IMM |->
		len_o == 2'h1 && ea_o == next_pc_o - 16'h0001)
		else $error("immediate length or literal address wrong");

	a_dir_short_page: assert property (
		s_done_ok ##0 mode_o == M_DIR_S |->
		len_o == 2'h1 && ea_o[15:8] == 8'h00)
		else $error("short direct left page zero");

	a_dir_long_word: assert property (
		s_done_ok ##0 mode_o == M_DIR_L |->
		len_o == 2'h2 && ea_o == word_q)
		else $error("long direct address wrong");

	a_idx_short_sum: assert property (
		s_done_ok ##0 mode_o == M_IDX_S |->
		ea_o == {ZERO_PAGE, idx_q} + {ZERO_PAGE, word_q[7:0]})
		else $error("short indexed sum wrong");

	a_idx_no_offset: assert property (
		s_done_ok ##0 mode_o == M_IDX0 |->
		len_o == 2'h0 && ea_o == {ZERO_PAGE, idx_q})
		else $error("indexed without offset wrong");

	a_idx_long_sum: assert property (
		s_done_ok ##0 mode_o == M_IDX_L |->
		len_o == 2'h2 && ea_o == word_q + {ZERO_PAGE, idx_q})
		else $error("long indexed sum wrong");

	a_ptr_follow: assert property (
		st_q == S_ARG1 && mem_ack_i && is_indirect(mode_q) |=>
		mem_req_o && mem_addr_o == {ZERO_PAGE, $past(mem_rdata_i)})
		else $error("pointer address not followed");

	a_ind_short_page: assert property (
		s_done_ok ##0 mode_o == M_IND_S |->
		len_o == 2'h1 && ea_o == {ZERO_PAGE, operand_o})
		else $error("short indirect address wrong");

	a_ptr_long_word: assert property (
		st_q == S_PTR1 && mem_ack_i && long_ptr(mode_q) |=>
		st_q == S_PTR2 && mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("word pointer second byte not read");

	a_iix_short_sum: assert property (
		s_done_ok ##0 mode_o == M_IIX_S |->
		ea_o == {ZERO_PAGE, idx_q} + {ZERO_PAGE, operand_o})
		else $error("short indirect indexed sum wrong");

	a_rel_target: assert property (
		s_done_ok ##0 mode_o inside {M_REL_D, M_REL_I} |->
		ea_o == next_pc_o + {{8{operand_o[7]}}, operand_o})
		else $error("relative target wrong");

	a_second_index: assert property (
		s_take ##0 (prebyte_i == PRE_SECOND_INDEX && mode_i == M_IDX0 &&
		start_ok) |-> ##2 ea_o == {ZERO_PAGE, $past(y_i, 2)})
		else $error("second index not used");

	a_indirect_pre: assert property (
		s_take ##0 (prebyte_i == PRE_INDIRECT && mode_i == M_DIR_S) |=>
		mode_q == M_IND_S)
		else $error("indirect prebyte ignored");

	a_short_family: assert property (
		s_take ##0 (op_class_i == OP_SHORT &&
		eff_mode inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L}) |->
		##2 done_o && err_o)
		else $error("long form accepted for short family");

endmodule : addr_mode_decoder
`default_nettype wire

// >>> mem_model.sv
`default_nettype none
module mem_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [3:0]  wait_i,
	output logic             ack_o,
	output logic [7:0]       rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [0:65535];
	logic [3:0] cnt_q;

	// Quiet bus at time zero
	initial begin
		ack_o = 1'h0;
		rdata_o = 8'h00;
		cnt_q = 4'h0;
	end

	// Answer after wait_i idle cycles; data toggles when not valid
	always @(posedge clk_i) begin
		if (req_i && !ack_o && cnt_q >= wait_i) begin
			ack_o <= 1'h1;
			rdata_o <= mem[addr_i];
			cnt_q <= 4'h0;
		end else begin
			ack_o <= 1'h0;
			rdata_o <= ~rdata_o; // Stale byte never looks valid
			cnt_q <= (req_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule : mem_model
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb
	import addr_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [15:0] OPC = 16'h1000;
	logic core_clk_i, arst_n_i, start_i, mem_ack_i, mem_req_o;
	logic busy_o, done_o, err_o, poke;
	mode_t mode_i, mode_o;
	op_class_t op_class_i;
	logic [7:0] prebyte_i, x_i, y_i, mem_rdata_i, operand_o;
	logic [15:0] opc_addr_i, mem_addr_o, ea_o, next_pc_o, first_addr;
	logic [1:0] len_o;
	logic [3:0] mem_wait;
	int num_errors, samples_checked, n_fetch;

	addr_mode_decoder dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.start_i(start_i), .mode_i(mode_i), .op_class_i(op_class_i),
		.prebyte_i(prebyte_i), .opc_addr_i(opc_addr_i), .x_i(x_i),
		.y_i(y_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .busy_o(busy_o),
		.done_o(done_o), .err_o(err_o), .ea_o(ea_o), .len_o(len_o),
		.mode_o(mode_o), .operand_o(operand_o), .next_pc_o(next_pc_o));
	mem_model mem_m (.clk_i(core_clk_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .wait_i(mem_wait), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));

	// 10 MHz core clock
	initial begin
		core_clk_i = 1'h0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// Count accepted reads and note the first address
	always @(posedge core_clk_i) begin
		if (mem_req_o && mem_ack_i) begin
			if (n_fetch == 0) first_addr = mem_addr_o;
			n_fetch++;
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, s);
		samples_checked++;
		if (e !== s) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	// Index values, operand bytes and zero-page pointer bytes
	task automatic prep(input logic [7:0] x, y, b1, b2, p0, p1);
		x_i = x;
		y_i = y;
		mem_m.mem[OPC + 16'h0001] = b1;
		mem_m.mem[OPC + 16'h0002] = b2;
		mem_m.mem[{8'h00, b1}] = p0;
		mem_m.mem[{8'h00, b1} + 16'h0001] = p1;
	endtask : prep

	// One decode; called and left at a falling edge, so chains run
	// back to back with the next start in the done cycle
	task automatic op(input mode_t m, input op_class_t c,
		input logic [7:0] p, input logic [15:0] e_ea,
		input logic [1:0] e_len, input mode_t e_m, input logic e_err,
		input int e_f);
		int k;
		mode_i = m;
		op_class_i = c;
		prebyte_i = p;
		start_i = 1'h1;
		n_fetch = 0;
		@(negedge core_clk_i);
		start_i = 1'h0;
		for (k = 0; k < 60 && done_o !== 1'h1; k++) begin
			if (poke && busy_o === 1'h1) begin
				start_i = 1'h1; // Must be ignored while busy
				mode_i = M_INH;
			end
			@(negedge core_clk_i);
		end
		start_i = 1'h0;
		if (k == 60) begin
			$display("MISMATCH done expected 1 seen 0");
			num_errors++;
			complete_run();
		end
		chk("err", 16'(e_err), 16'(err_o));
		chk("ea", e_ea, ea_o);
		chk("mode", 16'(e_m), 16'(mode_o));
		chk("fetches", 16'(e_f), 16'(n_fetch));
		chk("busy", 16'h0000, 16'(busy_o));
		if (e_f > 0) chk("first_addr", OPC + 16'h0001, first_addr);
		if (!e_err) begin
			chk("len", 16'(e_len), 16'(len_o));
			chk("next_pc", OPC + 16'h0001 + 16'(e_len), next_pc_o);
		end
	endtask : op

	////////////////////////////////////////////////////////////////////
	task automatic t_plain();
		prep(8'hF0, 8'h00, 8'hC7, 8'h34, 8'h00, 8'h00);
		op(M_INH, OP_INH, 8'h00, 16'h0000, 2'h0, M_INH, 1'h0, 0);
		op(M_INH, OP_INH, 8'h00, 16'h0000, 2'h0, M_INH, 1'h0, 0);
		op(M_IMM, OP_FULL, 8'h00, 16'h1001, 2'h1, M_IMM, 1'h0, 1);
		op(M_DIR_S, OP_FULL, 8'h00, 16'h00C7, 2'h1, M_DIR_S, 1'h0, 1);
		op(M_DIR_L, OP_FULL, 8'h00, 16'hC734, 2'h2, M_DIR_L, 1'h0, 2);
		op(M_IDX0, OP_SHORT, 8'h00, 16'h00F0, 2'h0, M_IDX0, 1'h0, 0);
		op(M_IDX_S, OP_FULL, 8'h00, 16'h01B7, 2'h1, M_IDX_S, 1'h0, 1);
		prep(8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00);
		op(M_IDX_S, OP_FULL, 8'h00, 16'h01FE, 2'h1, M_IDX_S, 1'h0, 1);
		op(M_IDX_L, OP_FULL, 8'h00, 16'h00FE, 2'h2, M_IDX_L, 1'h0, 2);
	endtask : t_plain

	task automatic t_indirect();
		prep(8'h80, 8'h00, 8'h40, 8'h00, 8'hAB, 8'hCD);
		op(M_IND_S, OP_FULL, 8'h00, 16'h00AB, 2'h1, M_IND_S, 1'h0, 2);
		op(M_IND_L, OP_FULL, 8'h00, 16'hABCD, 2'h1, M_IND_L, 1'h0, 3);
		op(M_IIX_S, OP_FULL, 8'h00, 16'h012B, 2'h1, M_IIX_S, 1'h0, 2);
		op(M_IIX_L, OP_FULL, 8'h00, 16'hAC4D, 2'h1, M_IIX_L, 1'h0, 3);
		prep(8'h10, 8'h00, 8'h40, 8'h00, 8'hFF, 8'hF8);
		op(M_IIX_L, OP_FULL, 8'h00, 16'h0008, 2'h1, M_IIX_L, 1'h0, 3);
	endtask : t_indirect

	task automatic t_relative();
		prep(8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00);
		op(M_REL_D, OP_REL, 8'h00, 16'h0F82, 2'h1, M_REL_D, 1'h0, 1);
		chk("operand", 16'h0080, 16'(operand_o));
		prep(8'h00, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00);
		op(M_REL_D, OP_REL, 8'h00, 16'h1081, 2'h1, M_REL_D, 1'h0, 1);
		prep(8'h00, 8'h00, 8'h40, 8'h00, 8'hFE, 8'h00);
		op(M_REL_I, OP_REL, 8'h00, 16'h1000, 2'h1, M_REL_I, 1'h0, 2);
		chk("operand", 16'h00FE, 16'(operand_o));
	endtask : t_relative

	task automatic t_prebyte();
		prep(8'h01, 8'h20, 8'h40, 8'h00, 8'h10, 8'h00);
		op(M_IDX_S, OP_FULL, 8'h90, 16'h0060, 2'h1, M_IDX_S, 1'h0, 1);
		op(M_DIR_S, OP_FULL, 8'h92, 16'h0010, 2'h1, M_IND_S, 1'h0, 2);
		op(M_IDX_S, OP_FULL, 8'h92, 16'h0011, 2'h1, M_IIX_S, 1'h0, 2);
		op(M_REL_D, OP_REL, 8'h92, 16'h1012, 2'h1, M_REL_I, 1'h0, 2);
		op(M_IIX_S, OP_FULL, 8'h91, 16'h0030, 2'h1, M_IIX_S, 1'h0, 2);
		op(M_IDX0, OP_FULL, 8'h90, 16'h0020, 2'h0, M_IDX0, 1'h0, 0);
	endtask : t_prebyte

	task automatic t_family();
		op(M_DIR_L, OP_SHORT, 8'h00, 16'h0000, 2'h2, M_DIR_L, 1'h1, 0);
		op(M_REL_D, OP_FULL, 8'h00, 16'h0000, 2'h1, M_REL_D, 1'h1, 0);
		op(M_DIR_S, OP_INH, 8'h00, 16'h0000, 2'h1, M_DIR_S, 1'h1, 0);
		op(M_DIR_S, OP_REL, 8'h00, 16'h0000, 2'h1, M_DIR_S, 1'h1, 0);
		op(M_IND_S, OP_SHORT, 8'h00, 16'h0010, 2'h1, M_IND_S, 1'h0, 2);
	endtask : t_family

	// Reset in mid-run clears the results at once
	task automatic t_reset();
		arst_n_i = 1'h0;
		@(negedge core_clk_i);
		chk("mid_ea", 16'h0000, ea_o);
		chk("mid_mode", 16'(M_INH), 16'(mode_o));
		arst_n_i = 1'h1;
		repeat (3) @(negedge core_clk_i);
	endtask : t_reset

	// Slow memory with start held high all through busy
	task automatic t_slow();
		mem_wait = 4'h3;
		poke = 1'h1;
		prep(8'h80, 8'h00, 8'h40, 8'h00, 8'hAB, 8'hCD);
		op(M_IND_L, OP_FULL, 8'h00, 16'hABCD, 2'h1, M_IND_L, 1'h0, 3);
		poke = 1'h0;
		mem_wait = 4'h0;
	endtask : t_slow

	////////////////////////////////////////////////////////////////////
	// Reset for three cycles, then run every scenario
	initial begin
		arst_n_i = 1'h0;
		start_i = 1'h0;
		mode_i = M_INH;
		op_class_i = OP_INH;
		prebyte_i = 8'h00;
		opc_addr_i = OPC;
		x_i = 8'h00;
		y_i = 8'h00;
		mem_wait = 4'h0;
		poke = 1'h0;
		num_errors = 0;
		samples_checked = 0;
		n_fetch = 0;
		repeat (3) @(negedge core_clk_i);
		arst_n_i = 1'h1;
		repeat (4) @(negedge core_clk_i);
		chk("rst_mode", 16'(M_INH), 16'(mode_o));
		chk("rst_busy", 16'h0000, 16'(busy_o));
		t_plain();
		t_reset();
		t_indirect();
		t_relative();
		t_prebyte();
		t_family();
		t_slow();
		complete_run();
	end
endmodule : tb
`default_nettype wire
